// >>> verilog/clk_sel_map.svh
// Purpose: register offsets, field positions, reset values, widths, settle count
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   definitions only
`ifndef CLK_SEL_MAP_SVH
`define CLK_SEL_MAP_SVH
`define CLOCK_SELECT_CONTROL_OFS    8'he9
`define CHANNEL_IRQ_STATUS_LOW_OFS  8'hea
`define CHANNEL_IRQ_STATUS_HIGH_OFS 8'heb
`define OUTPUT_CLOCK_GATE_BIT       5
`define TX_CLOCK_LOSS_ACTION_BIT    4
`define INPUT_CLOCK_SELECT_MSB      3
`define CLOCK_SELECT_RESET          8'h00
`define IRQ_FLAGS_RESET             14'h0000
`define IRQ_LOW_WIDTH               8
`define IRQ_HIGH_WIDTH              6
`define RETUNE_SETTLE_CYCLES        4'h8
`endif

// >>> verilog/clk_sel_pkg.sv
// Purpose: types shared by the clock select block
// Assumes: nothing
// Notes:   reference rates, retune states
package clk_sel_pkg;
  typedef enum logic [3:0] {
    ref_2m048  = 4'h0, ref_1m544  = 4'h1, ref_8k     = 4'h2,
    ref_16k    = 4'h3, ref_56k    = 4'h4, ref_64k    = 4'h5,
    ref_128k   = 4'h6, ref_256k   = 4'h7, ref_4m096  = 4'h8,
    ref_3m088  = 4'h9, ref_8m192  = 4'ha, ref_6m176  = 4'hb,
    ref_16m384 = 4'hc, ref_12m352 = 4'hd, ref_2m048b = 4'he,
    ref_1m544b = 4'hf
  } ref_rate_t;
  typedef enum logic [1:0] {
    pll_locked   = 2'b00,
    pll_retune   = 2'b01,
    pll_settle   = 2'b11
  } pll_state_t;
  typedef struct packed {
    pll_state_t state;
    logic [3:0] count;
    logic [3:0] target;
  } retune_t;
endpackage : clk_sel_pkg

// >>> verilog/pll_retune_if.sv
// Purpose: carries retune request and PLL status between modules
// Assumes: single clock
// Notes:   request is a one-cycle pulse
`timescale 1ns/1ps
interface pll_retune_if;
  logic                  req;
  clk_sel_pkg::ref_rate_t rate;
  logic                  busy;
  logic [3:0]            mult_code;
  modport ctrl (output req, output rate, input busy, input mult_code);
  modport pll  (input req, input rate, output busy, output mult_code);
endinterface : pll_retune_if

// >>> verilog/pll_retune.sv
// Purpose: retunes the PLL multiplier when the reference select changes
// Assumes: synthesizer settles in a fixed count of cycles
// Notes:   multiplier code equals the accepted reference code
`timescale 1ns/1ps
`include "clk_sel_map.svh"
module pll_retune (
  input wire logic    sys_clk,
  input wire logic    rstn,
  pll_retune_if.pll   rt
);
  clk_sel_pkg::retune_t st;
  clk_sel_pkg::retune_t next_st;

  // New request restarts the retune, even mid-settle
  always_comb
  begin
    next_st = st;
    case (st.state)
      clk_sel_pkg::pll_locked:
      begin
        if (rt.req)
        begin
          next_st.state  = clk_sel_pkg::pll_retune;
          next_st.target = rt.rate;
        end
      end
      clk_sel_pkg::pll_retune:
      begin
        next_st.state = clk_sel_pkg::pll_settle;
        next_st.count = `RETUNE_SETTLE_CYCLES;
      end
      clk_sel_pkg::pll_settle:
      begin
        if (st.count == 4'h1)
          next_st.state = clk_sel_pkg::pll_locked;
        next_st.count = st.count - 4'h1;
      end
      default:
        next_st.state = clk_sel_pkg::pll_locked;
    endcase
    if (rt.req && st.state != clk_sel_pkg::pll_locked)
    begin
      next_st.state  = clk_sel_pkg::pll_retune;
      next_st.target = rt.rate;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      st <= '{clk_sel_pkg::pll_locked, 4'h0, 4'h0};
    else
      st <= next_st;
  end

  assign rt.busy      = (st.state != clk_sel_pkg::pll_locked);
  assign rt.mult_code = st.target;
endmodule : pll_retune

// >>> verilog/global_clock_select_irq_status.sv
// Purpose: global clock select register and channel interrupt flags
// Assumes: 8-bit register port, one-cycle read and write strobes
// Notes:   read data is registered, flags clear after the read
// Operation
// - All clock references come from the chosen input; PLL times the port.
// - A new select code retunes the PLL to the new reference.
// - Bits 7 and 6 reserved, no function, reset to zero.
// - Bit 5 at 0 shuts output clocks except 8 kHz in E1.
// - Bit 4 picks zeros or ones when transmit clock is lost.
// - Low select codes pick 2.048M, 1.544M, 8k, 16k, 56k, 64k, 128k, 256k.
// - Low status register holds channel 0..7 flags, bit n channel n.
// - High status register holds channels 8..13; bits 7,6 read zero.
`timescale 1ns/1ps
`include "clk_sel_map.svh"
module global_clock_select_irq_status (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [13:0] channel_irq_event,
  input  wire logic        transmit_clock_lost,
  input  wire logic        tx_data_in,
  input  wire logic        e1_mode,
  input  wire logic [4:0]  clock_ref_in,
  output logic      [4:0]  clock_ref_out,
  output logic             line_tx_data,
  output logic      [3:0]  pll_mult_code,
  output logic             pll_busy,
  output logic             send_all_ones
);
  // Bit 0 of the clock reference group is the 8 kHz reference
  localparam int REF_8K = 0;

  typedef struct packed {
    logic       output_clock_gate;
    logic       tx_clock_loss_action;
    clk_sel_pkg::ref_rate_t input_clock_select;
    logic [13:0] channel_irq_flag;
    logic [7:0]  rdata;
    logic [4:0]  ref_out;
    logic        line_tx;
  } state_t;

  state_t st;
  state_t next_st;
  pll_retune_if rt ();

  // Address decode used by both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_ctrl;
  logic rd_low;
  logic rd_high;
  assign wr_ctrl = reg_wr && hit(reg_addr, `CLOCK_SELECT_CONTROL_OFS);
  assign rd_low  = reg_rd && hit(reg_addr, `CHANNEL_IRQ_STATUS_LOW_OFS);
  assign rd_high = reg_rd && hit(reg_addr, `CHANNEL_IRQ_STATUS_HIGH_OFS);

  // Retune only on a real change of code, so rewriting the upper nibble
  // does not disturb the PLL that times this very port
  assign rt.req  = wr_ctrl &&
    (reg_wdata[`INPUT_CLOCK_SELECT_MSB:0] != st.input_clock_select);
  // Select code passes straight through as the reference rate
  assign rt.rate = clk_sel_pkg::ref_rate_t'(reg_wdata[3:0]);

  pll_retune u_pll_retune (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .rt      (rt.pll)
  );

  always_comb
  begin
    next_st = st;
    // Register write; bits 7..6 are not stored
    if (wr_ctrl)
    begin
      next_st.output_clock_gate    =
        reg_wdata[`OUTPUT_CLOCK_GATE_BIT];
      next_st.tx_clock_loss_action =
        reg_wdata[`TX_CLOCK_LOSS_ACTION_BIT];
      next_st.input_clock_select   = rt.rate;
    end
    // Read mux, registered; unmapped reads return zero
    next_st.rdata = 8'h00;
    if (reg_rd && hit(reg_addr, `CLOCK_SELECT_CONTROL_OFS))
      next_st.rdata = {2'b00, st.output_clock_gate,
                       st.tx_clock_loss_action, st.input_clock_select};
    else if (rd_low)
      next_st.rdata = st.channel_irq_flag[7:0];
    else if (rd_high)
      next_st.rdata = {2'b00, st.channel_irq_flag[13:8]};
    // Clear what was returned, but a same-cycle event wins
    if (rd_low)
      next_st.channel_irq_flag[7:0] = 8'h00;
    if (rd_high)
      next_st.channel_irq_flag[13:8] = 6'h00;
    next_st.channel_irq_flag = next_st.channel_irq_flag | channel_irq_event;
    // Output gating; 8 kHz survives in E1 mode
    next_st.ref_out = st.output_clock_gate ? clock_ref_in : 5'h00;
    next_st.ref_out[REF_8K] = clock_ref_in[REF_8K] &&
                              (st.output_clock_gate || e1_mode);
    // Lost transmit clock forces zeros or ones onto the line
    next_st.line_tx = transmit_clock_lost ?
                      st.tx_clock_loss_action : tx_data_in;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      st <= '{1'b0, 1'b0, clk_sel_pkg::ref_2m048, `IRQ_FLAGS_RESET,
              8'h00, 5'h00, 1'b0};
    else
      st <= next_st;
  end

  assign reg_rdata     = st.rdata;
  assign clock_ref_out = st.ref_out;
  assign line_tx_data  = st.line_tx;
  assign pll_mult_code = rt.mult_code;
  assign pll_busy      = rt.busy;
  assign send_all_ones = transmit_clock_lost && st.tx_clock_loss_action;

  property p_flag_set;
    @(posedge sys_clk) disable iff (!rstn)
      channel_irq_event[3] |=> st.channel_irq_flag[3];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set flag");

  property p_read_clear;
    @(posedge sys_clk) disable iff (!rstn)
      (rd_low && !channel_irq_event[0]) |=> !st.channel_irq_flag[0];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not clear flag");

  property p_read_low;
    @(posedge sys_clk) disable iff (!rstn)
      rd_low |=> reg_rdata == $past(st.channel_irq_flag[7:0]);
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("low status read wrong");

  property p_high_res;
    @(posedge sys_clk) disable iff (!rstn)
      rd_high |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_high_res: assert property (p_high_res)
    else $error("reserved status bits set");

  property p_ctrl_res;
    @(posedge sys_clk) disable iff (!rstn)
      (reg_rd && hit(reg_addr, `CLOCK_SELECT_CONTROL_OFS))
      |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_ctrl_res: assert property (p_ctrl_res)
    else $error("reserved control bits set");

  property p_gate;
    @(posedge sys_clk) disable iff (!rstn)
      !st.output_clock_gate |=> clock_ref_out[4:1] == 4'h0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("clock output not gated");

  property p_loss;
    @(posedge sys_clk) disable iff (!rstn)
      transmit_clock_lost |=> line_tx_data == $past(st.tx_clock_loss_action);
  endproperty
  a_loss: assert property (p_loss)
    else $error("wrong line level on clock loss");

  property p_retune;
    @(posedge sys_clk) disable iff (!rstn)
      rt.req |=> pll_busy ##[1:12]
        (!pll_busy && pll_mult_code == st.input_clock_select);
  endproperty
  a_retune: assert property (p_retune)
    else $error("PLL did not retune");

  // Same code rewritten leaves the PLL alone, so the port keeps its clock
  property p_no_retune;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_ctrl && !rt.req && !pll_busy) |=> !pll_busy;
  endproperty
  a_no_retune: assert property (p_no_retune)
    else $error("PLL retuned without a code change");

  // A write must land in the select field
  property p_wr_select;
    @(posedge sys_clk) disable iff (!rstn)
      wr_ctrl |=> st.input_clock_select == $past(reg_wdata[3:0]);
  endproperty
  a_wr_select: assert property (p_wr_select)
    else $error("select code not stored");

  // A write must land in the gate and loss-action bits
  property p_wr_flags;
    @(posedge sys_clk) disable iff (!rstn)
      wr_ctrl |=> {st.output_clock_gate, st.tx_clock_loss_action} ==
        $past(reg_wdata[`OUTPUT_CLOCK_GATE_BIT:`TX_CLOCK_LOSS_ACTION_BIT]);
  endproperty
  a_wr_flags: assert property (p_wr_flags)
    else $error("control bits not stored");

  // High status read returns the channel 8..13 flags
  property p_high_read;
    @(posedge sys_clk) disable iff (!rstn)
      rd_high |=> reg_rdata[5:0] == $past(st.channel_irq_flag[13:8]);
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high status read wrong");

  // Gate open passes every reference unchanged
  property p_gate_on;
    @(posedge sys_clk) disable iff (!rstn)
      st.output_clock_gate |=> clock_ref_out == $past(clock_ref_in);
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("clock output blocked with gate open");

  // 8 kHz reference survives the gate in E1 mode
  property p_e1_keep;
    @(posedge sys_clk) disable iff (!rstn)
      e1_mode |=> clock_ref_out[REF_8K] == $past(clock_ref_in[REF_8K]);
  endproperty
  a_e1_keep: assert property (p_e1_keep)
    else $error("8 kHz reference lost in E1 mode");

  // Normal line data passes while the transmit clock runs
  property p_line_pass;
    @(posedge sys_clk) disable iff (!rstn)
      !transmit_clock_lost |=> line_tx_data == $past(tx_data_in);
  endproperty
  a_line_pass: assert property (p_line_pass)
    else $error("line data not passed through");
endmodule : global_clock_select_irq_status

// >>> bench/host_model.sv
// Purpose: host processor model on the register port
// Assumes: one-cycle strobes, read data valid after the read edge
// Notes:   idle bus shows inverted values, not the last ones
`timescale 1ns/1ps
`include "clk_sel_map.svh"
module host_model (
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  logic [7:0] cur = 8'h00; // Host copy of the select byte
  // Quiet bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write, strobe held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // One read, data taken right after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
  // Split so that no write touches both nibbles
  task automatic set_csel(input logic [7:0] v);
    if (v[7:4] != cur[7:4])
    begin
      cur = {v[7:4], cur[3:0]};
      wr(`CLOCK_SELECT_CONTROL_OFS, cur);
    end
    if (v[3:0] != cur[3:0])
    begin
      cur = v;
      wr(`CLOCK_SELECT_CONTROL_OFS, cur);
    end
  endtask : set_csel
endmodule : host_model

// >>> bench/testbench.sv
// Purpose: self-checking bench for clock select and channel flags
// Assumes: inputs change at falling edges
// Notes:   settle waits are bounded counts, not exact figures
`timescale 1ns/1ps
`include "clk_sel_map.svh"
module testbench;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic        reg_wr, reg_rd, line_tx_data, pll_busy, send_all_ones;
  logic [13:0] channel_irq_event = 14'h0000;
  logic        transmit_clock_lost = 1'b0;
  logic        tx_data_in = 1'b0;
  logic        e1_mode = 1'b0;
  logic [4:0]  clock_ref_in = 5'h1f;
  logic [4:0]  clock_ref_out;
  logic [3:0]  pll_mult_code;
  int          errors = 0;
  int          n_compared = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  global_clock_select_irq_status u_global_clock_select_irq_status (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_irq_event(channel_irq_event),
    .transmit_clock_lost(transmit_clock_lost), .tx_data_in(tx_data_in),
    .e1_mode(e1_mode), .clock_ref_in(clock_ref_in),
    .clock_ref_out(clock_ref_out), .line_tx_data(line_tx_data),
    .pll_mult_code(pll_mult_code), .pll_busy(pll_busy),
    .send_all_ones(send_all_ones));
  host_model u_host_model (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Compare helpers, four-state exact
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic g, input logic e);
    cmp_byte({7'h00, g}, {7'h00, e});
  endtask : cmp_bit
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, v);
    cmp_byte(v, e);
  endtask : rd_cmp
  task automatic give_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic check_reset;
    rd_cmp(`CLOCK_SELECT_CONTROL_OFS, 8'h00);
    rd_cmp(`CHANNEL_IRQ_STATUS_HIGH_OFS, 8'h00);
    cmp_byte({3'h0, clock_ref_out}, 8'h00);
  endtask : check_reset
  // Gate off keeps only 8 kHz in E1, gate on passes all
  task automatic check_gate;
    e1_mode = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp_byte({3'h0, clock_ref_out}, 8'h01);
    u_host_model.set_csel(8'h20);
    repeat (2) @(negedge sys_clk);
    cmp_byte({3'h0, clock_ref_out}, 8'h1f);
  endtask : check_gate
  // Line data forced to zeros, then ones, while clock lost
  task automatic check_tx_loss;
    transmit_clock_lost = 1'b1;
    tx_data_in = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp_bit(line_tx_data, 1'b0);
    u_host_model.set_csel(8'h30);
    repeat (2) @(negedge sys_clk);
    cmp_bit(line_tx_data, 1'b1);
    cmp_bit(send_all_ones, 1'b1);
    transmit_clock_lost = 1'b0;
    tx_data_in = 1'b0;
    repeat (2) @(negedge sys_clk);
    cmp_bit(send_all_ones, 1'b0);
    cmp_bit(line_tx_data, 1'b0);
  endtask : check_tx_loss
  // Every select code, ending back at code zero
  task automatic check_retune;
    int  i;
    int  n;
    logic seen;
    for (i = 1; i <= 16; i++)
    begin
      u_host_model.set_csel({4'h3, 4'(i)});
      seen = 1'b0;
      for (n = 0; n < 40 && !(seen && pll_busy === 1'b0); n++)
      begin
        if (pll_busy === 1'b1)
          seen = 1'b1;
        @(negedge sys_clk);
      end
      cmp_bit(seen, 1'b1);
      cmp_byte({4'h0, pll_mult_code}, {4'h0, 4'(i)});
    end
  endtask : check_retune
  // Reserved bits dropped; no retune on upper-nibble write; unmapped
  task automatic check_reserved;
    u_host_model.set_csel(8'hf0);
    rd_cmp(`CLOCK_SELECT_CONTROL_OFS, 8'h30);
    cmp_bit(pll_busy, 1'b0);
    u_host_model.wr(8'he8, 8'h55);
    rd_cmp(8'he8, 8'h00);
  endtask : check_reserved
  // Flags per channel, cleared by the read that returns them
  task automatic check_irq;
    channel_irq_event = 14'h2a5a;
    @(negedge sys_clk);
    channel_irq_event = 14'h0000;
    rd_cmp(`CHANNEL_IRQ_STATUS_LOW_OFS, 8'h5a);
    rd_cmp(`CHANNEL_IRQ_STATUS_LOW_OFS, 8'h00);
    rd_cmp(`CHANNEL_IRQ_STATUS_HIGH_OFS, 8'h2a);
    rd_cmp(`CHANNEL_IRQ_STATUS_HIGH_OFS, 8'h00);
    channel_irq_event = 14'h3fff;
    @(negedge sys_clk);
    channel_irq_event = 14'h0000;
    rd_cmp(`CHANNEL_IRQ_STATUS_HIGH_OFS, 8'h3f);
    rd_cmp(`CHANNEL_IRQ_STATUS_LOW_OFS, 8'hff);
  endtask : check_irq
  // Mid-run reset drops control byte, pending flags and a retune
  task automatic check_mid_reset;
    channel_irq_event = 14'h0101;
    u_host_model.set_csel(8'h25);
    channel_irq_event = 14'h0000;
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    u_host_model.cur = 8'h00;
    rd_cmp(`CLOCK_SELECT_CONTROL_OFS, 8'h00);
    rd_cmp(`CHANNEL_IRQ_STATUS_LOW_OFS, 8'h00);
    rd_cmp(`CHANNEL_IRQ_STATUS_HIGH_OFS, 8'h00);
    cmp_byte({4'h0, pll_mult_code}, 8'h00);
    cmp_bit(pll_busy, 1'b0);
    cmp_byte({3'h0, clock_ref_out}, 8'h01);
  endtask : check_mid_reset
  // Main sequence
  initial
  begin
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    check_reset;
    check_gate;
    check_tx_loss;
    check_retune;
    check_reserved;
    check_irq;
    check_mid_reset;
    give_verdict;
  end
  // Watchdog, far beyond the run's few hundred cycles
  initial
  begin
    #2000000;
    errors++;
    give_verdict;
  end
endmodule : testbench
